//--- hdl/pci_pkg.sv
package pci_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] RISE_EDGE_ENABLE_OFS = 8'h00; // rising edge enables
    localparam logic [7:0] FALL_EDGE_ENABLE_OFS = 8'h04; // falling edge enables
    localparam logic [7:0] EDGE_FLAGS_OFS = 8'h08; // per-pin sticky flags
    localparam logic [7:0] IRQ_CONTROL_OFS = 8'h0C; // master enable, summary flag
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h10; // sticky event status, w1c
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14; // event mask

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MASTER_EN_BIT = 0; // master enable in control word
    localparam int CTRL_SUMMARY_BIT = 1; // summary flag in control word
    localparam int STAT_EDGE_BIT = 0; // any enabled edge seen
    localparam int STAT_WAKE_BIT = 1; // enabled edge seen while asleep with master enable set
    localparam int STAT_WIDTH = 2; // events in status register

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN_REG_RESET = 8'h00; // enables and flags
    localparam logic [STAT_WIDTH-1:0] STAT_RESET = 2'h0; // status and mask
    localparam logic [1:0] RESP_OKAY = 2'b00; // axi okay
    localparam logic [1:0] RESP_SLVERR = 2'b10; // axi slave error

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rise; // rising edge enables
        logic [7:0] fall; // falling edge enables
        logic masterEn; // master change-interrupt enable
    } pci_cfg_t;

    typedef enum logic [1:0] {
        PCI_W_IDLE = 2'b00, // waiting for address and data
        PCI_W_RESP = 2'b01 // response pending
    } pci_wstate_t;

endpackage

//--- hdl/pci_pin_change.sv
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Operation
// - per-pin rising detector gated by rise enable
// - falling detected only when fall enable set
// - both enables set detect either direction
// - enabled edge sets sticky pin flag
// - flags set always; request needs master enable
// - summary flag is OR of pin flags
// - software writes zero to clear flag
// - edge during flag write keeps flag set
// - enabled change wakes sleep when master set
// - sleep edge recorded before first instruction
// - enables and flags reset to zero
module pci_pin_change
    import pci_pkg::*;
#(
    parameter int PINS = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [PINS-1:0] pinIn,
    input wire logic sleepActive,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic changeIrq_q,
    output logic wakeReq_q,
    output logic irq_q
);

    // ----------------------------------------------------------------
    // pin synchroniser and edge detect
    // ----------------------------------------------------------------
    logic [PINS-1:0] pinMeta_q; // first stage, read only by second
    logic [PINS-1:0] pinSync_q; // second stage
    logic [PINS-1:0] pinPrev_q; // previous synchronised sample
    logic [PINS-1:0] riseSeen; // rising transitions this cycle
    logic [PINS-1:0] fallSeen; // falling transitions this cycle
    logic [PINS-1:0] edgeHit; // enabled edges this cycle
    pci_cfg_t cfg_q; // software configuration
    logic [PINS-1:0] pinFlags_q; // sticky per-pin flags
    logic [PINS-1:0] pinFlags_d; // next flags
    logic [STAT_WIDTH-1:0] irqStat_q; // sticky event status
    logic [STAT_WIDTH-1:0] irqMask_q; // event mask
    logic summaryFlag; // OR of pin flags

    // two-flop sync then sample history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
            pinPrev_q <= '0;
        end else begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // compare current sample with previous
    assign riseSeen = pinSync_q & ~pinPrev_q;
    assign fallSeen = ~pinSync_q & pinPrev_q;
    // either enable may fire; both set gives both directions
    assign edgeHit = (riseSeen & cfg_q.rise[PINS-1:0])
        | (fallSeen & cfg_q.fall[PINS-1:0]);
    assign summaryFlag = |pinFlags_q;

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    pci_wstate_t wState_q; // write state
    logic [7:0] wAddr_q; // latched write address
    logic [31:0] wData_q; // latched write data
    logic [3:0] wStrb_q; // latched strobes
    logic haveAddr_q; // address captured
    logic haveData_q; // data captured
    logic wrFire; // registers written this cycle
    logic wrLane0; // low byte lane enabled

    assign wrFire = (wState_q == PCI_W_IDLE) && haveAddr_q && haveData_q;
    assign wrLane0 = wStrb_q[0];

    // take address and data in either order, then answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wState_q <= PCI_W_IDLE;
            wAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            haveAddr_q <= 1'b0;
            haveData_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            unique case (wState_q)
                PCI_W_IDLE: begin
                    // address accept
                    if (s_axi_awvalid && !haveAddr_q && !s_axi_awready) begin
                        s_axi_awready <= 1'b1;
                        wAddr_q <= s_axi_awaddr[7:0];
                        haveAddr_q <= 1'b1;
                    end
                    // data accept
                    if (s_axi_wvalid && !haveData_q && !s_axi_wready) begin
                        s_axi_wready <= 1'b1;
                        wData_q <= s_axi_wdata;
                        wStrb_q <= s_axi_wstrb;
                        haveData_q <= 1'b1;
                    end
                    // both held: write lands, response next
                    if (wrFire) begin
                        haveAddr_q <= 1'b0;
                        haveData_q <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        wState_q <= PCI_W_RESP;
                        s_axi_bresp <= (wAddr_q <= IRQ_MASK_OFS && wAddr_q[1:0] == 2'b00)
                            ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                PCI_W_RESP: begin
                    // hold response until taken
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wState_q <= PCI_W_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q.rise <= PIN_REG_RESET;
            cfg_q.fall <= PIN_REG_RESET;
            cfg_q.masterEn <= 1'b0;
            irqMask_q <= STAT_RESET;
        end else if (wrFire && wrLane0) begin
            unique case (wAddr_q)
                RISE_EDGE_ENABLE_OFS: cfg_q.rise <= wData_q[7:0];
                FALL_EDGE_ENABLE_OFS: cfg_q.fall <= wData_q[7:0];
                IRQ_CONTROL_OFS: cfg_q.masterEn <= wData_q[CTRL_MASTER_EN_BIT];
                IRQ_MASK_OFS: irqMask_q <= wData_q[STAT_WIDTH-1:0];
                default: begin
                    // flags and status handled elsewhere
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // per-pin flags: software writes, hardware set wins
    // ----------------------------------------------------------------
    always_comb begin
        pinFlags_d = pinFlags_q;
        if (wrFire && wrLane0 && wAddr_q == EDGE_FLAGS_OFS) begin
            pinFlags_d = wData_q[PINS-1:0];
        end
        pinFlags_d = pinFlags_d | edgeHit;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinFlags_q <= '0;
        end else begin
            pinFlags_q <= pinFlags_d;
        end
    end

    // ----------------------------------------------------------------
    // request, wake and interrupt status
    // ----------------------------------------------------------------
    logic [STAT_WIDTH-1:0] statSet; // events this cycle
    logic statClr; // w1c write this cycle

    // edge and wake events this cycle, one driver for the whole vector
    always_comb begin
        statSet = '0;
        statSet[STAT_EDGE_BIT] = |edgeHit;
        statSet[STAT_WAKE_BIT] = sleepActive && cfg_q.masterEn && (|edgeHit);
    end
    assign statClr = wrFire && wrLane0 && wAddr_q == IRQ_STATUS_OFS;

    // request and wake levels, registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            changeIrq_q <= 1'b0;
            wakeReq_q <= 1'b0;
            irq_q <= 1'b0;
            irqStat_q <= STAT_RESET;
        end else begin
            changeIrq_q <= cfg_q.masterEn && (|pinFlags_d);
            wakeReq_q <= sleepActive && cfg_q.masterEn && (|pinFlags_d);
            // set wins over write-one clear
            if (statClr) begin
                irqStat_q <= (irqStat_q & ~wData_q[STAT_WIDTH-1:0]) | statSet;
            end else begin
                irqStat_q <= irqStat_q | statSet;
            end
            irq_q <= |(irqMask_q & ((statClr ? irqStat_q & ~wData_q[STAT_WIDTH-1:0]
                : irqStat_q) | statSet));
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic [31:0] rdWord; // decoded read value
    logic rdOk; // mapped address

    always_comb begin
        rdWord = 32'h0000_0000;
        rdOk = 1'b1;
        unique case (s_axi_araddr[7:0])
            RISE_EDGE_ENABLE_OFS: rdWord[7:0] = cfg_q.rise;
            FALL_EDGE_ENABLE_OFS: rdWord[7:0] = cfg_q.fall;
            EDGE_FLAGS_OFS: rdWord[PINS-1:0] = pinFlags_q;
            IRQ_CONTROL_OFS: begin
                rdWord[CTRL_MASTER_EN_BIT] = cfg_q.masterEn;
                rdWord[CTRL_SUMMARY_BIT] = summaryFlag;
            end
            IRQ_STATUS_OFS: rdWord[STAT_WIDTH-1:0] = irqStat_q;
            IRQ_MASK_OFS: rdWord[STAT_WIDTH-1:0] = irqMask_q;
            default: rdOk = 1'b0;
        endcase
        if (s_axi_araddr[31:8] != 24'h00_0000) begin
            rdOk = 1'b0;
            rdWord = 32'h0000_0000;
        end
    end

    // one read at a time; data only after the address handshake has completed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arready) begin
                // address taken at this edge, answer follows
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence riseOnPin0;
        pinSync_q[0] && !pinPrev_q[0] && cfg_q.rise[0];
    endsequence

    // enabled change while asleep with master enable set
    sequence wakeEdgeInSleep;
        sleepActive && cfg_q.masterEn && (|edgeHit);
    endsequence

    // pin 5 flag clear and no software write to the flags
    sequence flag5QuietNoWrite;
        !pinFlags_q[5] && !(wrFire && wrLane0 && wAddr_q == EDGE_FLAGS_OFS);
    endsequence

    a_rise_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
        riseOnPin0 |=> pinFlags_q[0])
        else $error("enabled rise did not set flag");

    a_fall_gated_off: assert property (@(posedge clock) disable iff (!rst_n)
        (!cfg_q.fall[0] && !cfg_q.rise[0] && !pinFlags_q[0] && !wrFire)
        |=> !pinFlags_q[0])
        else $error("flag set with both enables clear");

    a_both_edges_fire: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg_q.rise[1] && cfg_q.fall[1] && (pinSync_q[1] != pinPrev_q[1]))
        |=> pinFlags_q[1])
        else $error("change missed with both enables");

    a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        (pinFlags_q[2] && !(wrFire && wAddr_q == EDGE_FLAGS_OFS)) |=> pinFlags_q[2])
        else $error("flag dropped without software write");

    a_master_gates_req: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 changeIrq_q |-> $past(cfg_q.masterEn) && (|pinFlags_q))
        else $error("request without master enable or flag");

    a_summary_or: assert property (@(posedge clock) disable iff (!rst_n)
        (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        && s_axi_araddr[31:8] == 24'h00_0000 && s_axi_araddr[7:0] == IRQ_CONTROL_OFS)
        |=> s_axi_rdata[CTRL_SUMMARY_BIT] == $past(|pinFlags_q))
        else $error("summary flag not the OR of flags");

    a_write_zero_clears: assert property (@(posedge clock) disable iff (!rst_n)
        (wrFire && wrLane0 && wAddr_q == EDGE_FLAGS_OFS && !wData_q[3] && !edgeHit[3])
        |=> !pinFlags_q[3])
        else $error("written zero did not clear flag");

    a_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (wrFire && wAddr_q == EDGE_FLAGS_OFS && edgeHit[4]) |=> pinFlags_q[4])
        else $error("edge lost during flag write");

    a_wake_in_sleep: assert property (@(posedge clock) disable iff (!rst_n)
        wakeEdgeInSleep |=> wakeReq_q && pinFlags_q != '0)
        else $error("no wake on enabled change in sleep");

    a_wake_has_flag: assert property (@(posedge clock) disable iff (!rst_n)
        wakeReq_q |-> pinFlags_q != '0 && $past(sleepActive))
        else $error("wake raised before the flag was recorded");

    a_master_off_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        !cfg_q.masterEn |=> !changeIrq_q && !wakeReq_q)
        else $error("request or wake while master enable clear");

    a_flag_needs_edge: assert property (@(posedge clock) disable iff (!rst_n)
        flag5QuietNoWrite ##1 pinFlags_q[5] |-> $past(edgeHit[5]))
        else $error("flag set without an enabled edge");

    a_reset_clear: assert property (@(posedge clock)
        $rose(rst_n) |-> cfg_q.rise == PIN_REG_RESET && pinFlags_q == '0)
        else $error("enables or flags not zero after reset");

endmodule

//--- test/pci_pin_model.sv
`timescale 1ns/1ps
module pci_pin_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] pinTarget, // levels the bench asks for
    input wire logic sleepReq, // one-cycle request to enter sleep
    input wire logic wakeReq_q, // wake level from the block
    output logic [7:0] pinIn, // external port pins
    output logic sleepActive // core asleep
);
    // ------------------------------------------------------------
    // external pins and sleeping core
    // ------------------------------------------------------------
    // pins follow requested levels one edge later, even during reset
    always_ff @(posedge clock) begin
        pinIn <= pinTarget;
    end

    // core sleeps on request, leaves sleep on the wake level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleepActive <= 1'h0; // core awake after reset
        end else if (wakeReq_q) begin
            sleepActive <= 1'h0; // woken by an enabled change
        end else if (sleepReq) begin
            sleepActive <= 1'h1; // enter sleep
        end
    end
endmodule

//--- test/port_pin_change_interrupt_tb.sv
`timescale 1ns/1ps
module port_pin_change_interrupt_tb import pci_pkg::*;;
    // ------------------------------------------------------------
    // signals and scoreboard
    // ------------------------------------------------------------
    logic clock, rst_n, sleepReq, sleepActive, wakeReq_q, changeIrq_q, irq_q;
    logic [7:0] pinTarget, pinIn, r, f, p0, p1, e;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [33:0] rdQ[$]; // expected {resp, data} of pending reads
    logic [1:0] bQ[$]; // expected write responses
    logic [33:0] expR; // oldest read note
    int errTotal = 0;
    int nCompared = 0;

    // free-running 125 MHz clock
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    pci_pin_change #(.PINS(8)) pci_pin_change_inst (
        .clock(clock), .rst_n(rst_n), .pinIn(pinIn), .sleepActive(sleepActive),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .changeIrq_q(changeIrq_q),
        .wakeReq_q(wakeReq_q), .irq_q(irq_q)
    );

    pci_pin_model pci_pin_model_inst (
        .clock(clock), .rst_n(rst_n), .pinTarget(pinTarget), .sleepReq(sleepReq),
        .wakeReq_q(wakeReq_q), .pinIn(pinIn), .sleepActive(sleepActive)
    );

    // ------------------------------------------------------------
    // comparison, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // write: address and data offered together, each released when taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rsp);
        int n;
        @(posedge clock);
        bQ.push_back(rsp);
        awaddr <= {24'h00_0000, a};
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid && n < 50);
        bready <= 1'h0;
    endtask

    // read: note the expectation, hold the address until taken, then wait for the answer
    task automatic axiRead(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rsp);
        int n;
        @(posedge clock);
        rdQ.push_back({rsp, v});
        araddr <= {24'h00_0000, a};
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (!rvalid && n < 50);
        rready <= 1'h0;
    endtask

    // drive pin levels and let sync and detect settle
    task automatic setPins(input logic [7:0] v);
        @(posedge clock);
        pinTarget <= v;
        repeat (8) @(posedge clock);
    endtask

    // every mapped register reads zero
    task automatic regsZero();
        for (int i = 0; i < 6; i++) axiRead(8'(i * 4), 32'h0000_0000, RESP_OKAY);
    endtask

    // monitor: each answer is compared with the oldest note
    always @(posedge clock) begin
        if (bvalid === 1'h1 && bready === 1'h1) begin
            check({30'h0, bresp}, {30'h0, bQ.pop_front()});
        end
        if (rvalid === 1'h1 && rready === 1'h1) begin
            expR = rdQ.pop_front();
            check(rdata, expR[31:0]);
            check({30'h0, rresp}, {30'h0, expR[33:32]});
        end
    end

    // hang guard
    initial begin
        repeat (30000) @(posedge clock);
        errTotal++;
        summarize();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        pinTarget = 8'h00;
        sleepReq = 1'h0;
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        void'($urandom(32'h1f32_062b));
        repeat (16) @(posedge clock);
        rst_n <= 1'h1;
        regsZero();
        axiRead(8'h18, 32'h0000_0000, RESP_SLVERR); // unmapped
        axiRead(8'h02, 32'h0000_0000, RESP_SLVERR); // unaligned
        axiWrite(8'h18, $urandom, RESP_SLVERR);
        $display("test reset and map done");
        // random read-back, only low byte lane writes
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            axiWrite(8'(i * 4), d, RESP_OKAY);
            axiRead(8'(i * 4), {24'h00_0000, d[7:0]}, RESP_OKAY);
        end
        wstrb <= 4'he;
        axiWrite(EDGE_FLAGS_OFS, ~d, RESP_OKAY);
        wstrb <= 4'hf;
        axiRead(EDGE_FLAGS_OFS, {24'h00_0000, d[7:0]}, RESP_OKAY);
        $display("test read-back done");
        // random enables and pin transitions
        repeat (12) begin
            {r, f, p0, p1} = $urandom;
            setPins(p0);
            axiWrite(RISE_EDGE_ENABLE_OFS, {24'h00_0000, r}, RESP_OKAY);
            axiWrite(FALL_EDGE_ENABLE_OFS, {24'h00_0000, f}, RESP_OKAY);
            axiWrite(EDGE_FLAGS_OFS, 32'h0000_0000, RESP_OKAY);
            setPins(p1);
            e = (r & ~p0 & p1) | (f & p0 & ~p1);
            axiRead(EDGE_FLAGS_OFS, {24'h00_0000, e}, RESP_OKAY);
            axiRead(IRQ_CONTROL_OFS, {30'h0, |e, 1'h0}, RESP_OKAY);
            check({31'h0, changeIrq_q}, 32'h0000_0000);
        end
        $display("test edge detection done");
        // flags set with master off, then master on
        setPins(8'h00);
        axiWrite(RISE_EDGE_ENABLE_OFS, 32'h0000_00ff, RESP_OKAY);
        axiWrite(FALL_EDGE_ENABLE_OFS, 32'h0000_0000, RESP_OKAY);
        axiWrite(EDGE_FLAGS_OFS, 32'h0000_0000, RESP_OKAY);
        setPins(8'hff);
        check({31'h0, changeIrq_q}, 32'h0000_0000);
        axiWrite(IRQ_CONTROL_OFS, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge clock);
        check({31'h0, changeIrq_q}, 32'h0000_0001);
        axiRead(IRQ_CONTROL_OFS, 32'h0000_0003, RESP_OKAY);
        // read-mask-write clears only the known low nibble
        axiWrite(EDGE_FLAGS_OFS, 32'h0000_00f0, RESP_OKAY);
        axiRead(EDGE_FLAGS_OFS, 32'h0000_00f0, RESP_OKAY);
        axiWrite(EDGE_FLAGS_OFS, 32'h0000_0000, RESP_OKAY);
        repeat (2) @(posedge clock);
        check({31'h0, changeIrq_q}, 32'h0000_0000);
        $display("test master enable and clearing done");
        // edge lands after (k=0), with (k=1) or before (k>1) the clearing write
        for (int k = 0; k < 4; k++) begin
            setPins(8'h00);
            fork
                begin
                    repeat (k) @(posedge clock);
                    axiWrite(EDGE_FLAGS_OFS, 32'h0000_0000, RESP_OKAY);
                end
                pinTarget <= 8'h01;
            join
            repeat (8) @(posedge clock);
            axiRead(EDGE_FLAGS_OFS, {31'h0, k < 2}, RESP_OKAY);
        end
        $display("test edge during clear done");
        // status, mask and interrupt level
        setPins(8'h00);
        axiWrite(IRQ_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
        axiWrite(IRQ_MASK_OFS, 32'h0000_0000, RESP_OKAY);
        axiRead(IRQ_STATUS_OFS, 32'h0000_0000, RESP_OKAY);
        setPins(8'h02);
        axiRead(IRQ_STATUS_OFS, 32'h0000_0001, RESP_OKAY);
        check({31'h0, irq_q}, 32'h0000_0000);
        axiWrite(IRQ_MASK_OFS, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge clock);
        check({31'h0, irq_q}, 32'h0000_0001);
        axiWrite(IRQ_STATUS_OFS, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge clock);
        check({31'h0, irq_q}, 32'h0000_0000);
        $display("test interrupt done");
        // sleep, wake on an enabled change, flag ready on waking
        axiWrite(EDGE_FLAGS_OFS, 32'h0000_0000, RESP_OKAY);
        axiWrite(IRQ_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
        @(posedge clock);
        sleepReq <= 1'h1;
        @(posedge clock);
        sleepReq <= 1'h0;
        @(posedge clock);
        check({31'h0, sleepActive}, 32'h0000_0001);
        setPins(8'h06);
        check({31'h0, sleepActive}, 32'h0000_0000);
        axiRead(EDGE_FLAGS_OFS, 32'h0000_0004, RESP_OKAY);
        axiRead(IRQ_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
        $display("test sleep wake done");
        // second reset in mid-run clears everything
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        regsZero();
        check({29'h0, changeIrq_q, wakeReq_q, irq_q}, 32'h0000_0000);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
